// file: tpk_keepalive.sv
// Transmit-side pulse density guard with keep-alive substitution.
// Assumes source and received bits are synchronous to clock.
// Overview of operation
// - Transmitted bits keep an average ones density of at least one in eight.
// - No run of more than eighty zeros is sent; the run is caught before that.
// - Payload that would break the density limits is replaced by keep-alive.
// - Keep-alive option one sends every bit as a one with no framing.
// - Option two sends 193-bit frames, one framing bit then 192 ones.
// - Option two framing bits follow a twelve-frame pattern, counted mod 12.
// - Option three loops the regenerated received bits back to the output.
`timescale 1ns/1ps
`default_nettype none
module tpk_keepalive #(
   parameter logic [11:0] FRAME_PATTERN = tpk_pkg::FRAME_PATTERN_RST
) (
   input  wire logic       clock,
   input  wire logic       arst_n,
   input  wire logic       srcBit,
   input  wire logic       srcValid,
   output var  logic       srcReady,
   input  wire logic [1:0] kaMode,
   input  wire logic       rxBit,
   output var  logic       txBit,
   output var  logic       txStrobe,
   output var  logic       kaActive
);
   localparam logic [7:0] DIV_LAST   = 8'(tpk_pkg::BIT_DIV - 1);
   localparam logic [6:0] ZERO_LIM   = 7'(tpk_pkg::ZERO_MAX);
   localparam logic [5:0] CRED_CAP   = 6'(tpk_pkg::CREDIT_CAP);
   localparam logic [5:0] CRED_ONE   = 6'(tpk_pkg::ONE_CREDIT);
   localparam logic [7:0] FRAME_LAST = 8'(tpk_pkg::FRAME_BITS - 1);
   localparam logic [3:0] FCNT_LAST  = 4'(tpk_pkg::FRAME_COUNT - 1);
   localparam logic [7:0] KA_LAST    = 8'(tpk_pkg::KA_MIN_BITS - 1);

   logic [7:0]          divReg;
   logic                tick;
   logic [7:0]          bitCntReg;
   logic [3:0]          frameCntReg;
   logic [6:0]          zeroRunReg;
   logic [5:0]          creditReg;
   logic [7:0]          kaCntReg;
   tpk_pkg::tpk_state_t stateReg;
   logic                bufMem [2];
   logic                wrPtrReg;
   logic                rdPtrReg;
   logic [1:0]          countReg;
   logic [1:0]          countNext;
   logic                push;
   logic                pop;
   logic                headBit;
   logic                haveData;
   logic                violate;
   logic                sendPay;
   logic                kaBit;
   logic                nextBit;
   logic                frameBitVal;

   // Bit-rate enable from the system clock
   assign tick = (divReg == DIV_LAST);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         divReg <= 8'h00;
      end else begin
         divReg <= tick ? 8'h00 : divReg + 8'h01;
      end
   end

   // Framing counters run freely so option two never restarts mid-frame
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bitCntReg   <= 8'h00;
         frameCntReg <= 4'h0;
      end else if (tick) begin
         bitCntReg <= (bitCntReg == FRAME_LAST) ? 8'h00 : bitCntReg + 8'h01;
         if (bitCntReg == FRAME_LAST) begin
            frameCntReg <= (frameCntReg == FCNT_LAST) ? 4'h0 :
                           frameCntReg + 4'h1;
         end
      end
   end

   // Two-entry buffer; a stalled line pushes back on the source
   assign headBit   = bufMem[rdPtrReg];
   assign haveData  = (countReg != 2'h0);
   assign push      = srcValid && srcReady;
   assign pop       = tick && (stateReg == tpk_pkg::ST_DATA) && sendPay;
   assign countNext = countReg + {1'b0, push} - {1'b0, pop};

   always_ff @(posedge clock) begin
      if (push) begin
         bufMem[wrPtrReg] <= srcBit;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtrReg <= 1'b0;
         rdPtrReg <= 1'b0;
         countReg <= 2'h0;
         srcReady <= 1'b0;
      end else begin
         wrPtrReg <= wrPtrReg ^ push;
         rdPtrReg <= rdPtrReg ^ pop;
         countReg <= countNext;
         srcReady <= (countNext != 2'h2);
      end
   end

   // Leaky bucket: a one earns seven credits, a zero spends one
   assign violate = !haveData ||
                    (!headBit && ((zeroRunReg == ZERO_LIM) ||
                                  (creditReg == 6'h00)));
   assign sendPay = !violate;

   assign frameBitVal = FRAME_PATTERN[frameCntReg];
   always_comb begin
      unique case (tpk_pkg::tpk_ka_t'(kaMode))
         tpk_pkg::KA_FRAMED:
            kaBit = (bitCntReg == 8'h00) ? frameBitVal : 1'b1;
         tpk_pkg::KA_LOOP:
            kaBit = rxBit;
         tpk_pkg::KA_ONES, tpk_pkg::KA_DEFAULT:
            kaBit = 1'b1;
      endcase
   end
   assign nextBit = (stateReg == tpk_pkg::ST_DATA && sendPay) ? headBit
                                                              : kaBit;

   // Keep-alive lasts at least one frame, then payload resumes if present
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stateReg <= tpk_pkg::ST_KEEP;
         kaCntReg <= 8'h00;
      end else if (tick) begin
         unique case (stateReg)
            tpk_pkg::ST_DATA: begin
               if (violate) begin
                  stateReg <= tpk_pkg::ST_KEEP;
                  kaCntReg <= 8'h00;
               end
            end
            tpk_pkg::ST_KEEP: begin
               if (kaCntReg != KA_LAST) begin
                  kaCntReg <= kaCntReg + 8'h01;
               end else if (haveData) begin
                  stateReg <= tpk_pkg::ST_DATA;
               end
            end
         endcase
      end
   end

   // Counters restart on keep-alive since loopback content is the network's
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         zeroRunReg <= 7'h00;
         creditReg  <= CRED_CAP;
      end else if (tick) begin
         if (stateReg == tpk_pkg::ST_KEEP) begin
            zeroRunReg <= 7'h00;
            creditReg  <= CRED_CAP;
         end else if (sendPay && headBit) begin
            zeroRunReg <= 7'h00;
            creditReg  <= (creditReg > CRED_CAP - CRED_ONE) ? CRED_CAP
                          : creditReg + CRED_ONE;
         end else if (sendPay) begin
            zeroRunReg <= zeroRunReg + 7'h01;
            creditReg  <= creditReg - 6'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         txBit    <= 1'b1;
         txStrobe <= 1'b0;
         kaActive <= 1'b1;
      end else begin
         txStrobe <= tick;
         if (tick) begin
            txBit    <= nextBit;
            kaActive <= !(stateReg == tpk_pkg::ST_DATA && sendPay);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   runCap_a: assert property (zeroRunReg <= ZERO_LIM)
      else $error("zero run above limit");
   densityOk_a: assert property (
      (pop && !headBit) |-> (creditReg != 6'h00) ##1
      (creditReg == $past(creditReg) - 6'h01))
      else $error("zero sent with no density credit");
   kaSwitch_a: assert property (
      (tick && stateReg == tpk_pkg::ST_DATA && violate)
      |=> (stateReg == tpk_pkg::ST_KEEP) && kaActive)
      else $error("violation did not start keep-alive");
   allOnes_a: assert property (
      (tick && stateReg == tpk_pkg::ST_KEEP && kaMode == 2'b01) |=> txBit)
      else $error("option one sent a zero");
   frameOnes_a: assert property (
      (tick && stateReg == tpk_pkg::ST_KEEP && kaMode == 2'b10 &&
       bitCntReg != 8'h00) |=> txBit)
      else $error("framed payload bit not one");
   frameBit_a: assert property (
      (tick && stateReg == tpk_pkg::ST_KEEP && kaMode == 2'b10 &&
       bitCntReg == 8'h00)
      |=> txBit == FRAME_PATTERN[$past(frameCntReg)])
      else $error("framing bit off pattern");
   frameWrap_a: assert property (
      (tick && bitCntReg == FRAME_LAST && frameCntReg == FCNT_LAST)
      |=> frameCntReg == 4'h0)
      else $error("frame counter not modulo twelve");
   loopBack_a: assert property (
      (tick && stateReg == tpk_pkg::ST_KEEP && kaMode == 2'b11)
      |=> txBit == $past(rxBit))
      else $error("loopback bit mismatch");
   strobeGap_a: assert property (txStrobe |=> !txStrobe [*3])
      else $error("bit strobes too close");

   dataRun_c: cover property (pop ##[1:300] pop);
   // Credit cap keeps zero runs short, so the density trip comes first
   runTrip_c: cover property (tick && violate && haveData && !headBit);
   framedKa_c: cover property (tick && stateReg == tpk_pkg::ST_KEEP &&
                               kaMode == 2'b10 && frameCntReg == FCNT_LAST);
   backPress_c: cover property (srcValid && !srcReady);
endmodule
`default_nettype wire

// file: tpk_keepalive_tb.sv
// Self-checking bench for the pulse density keep-alive guard.
// Assumes tpk_pkg, the guard and the line model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tpk_keepalive_tb;
   localparam logic [11:0] FP = tpk_pkg::FRAME_PATTERN_RST;
   logic       clock, arst_n, srcBit, srcValid, srcReady, rxBit;
   logic       txBit, txStrobe, kaActive;
   logic [1:0] kaMode;
   int         errTotal, cmpCount, n, zRun, ones, kaCount, k0;
   logic       expq[$];
   // Payload rows; in data mode the line must show them unchanged
   logic [7:0] rows [4] = '{8'hff, 8'h81, 8'ha5, 8'hc0};

   tpk_keepalive #(.FRAME_PATTERN(FP)) tpk_keepalive_i (
      .clock(clock), .arst_n(arst_n), .srcBit(srcBit),
      .srcValid(srcValid), .srcReady(srcReady), .kaMode(kaMode),
      .rxBit(rxBit), .txBit(txBit), .txStrobe(txStrobe),
      .kaActive(kaActive));
   tpk_line_model tpk_line_model_i (.clock(clock), .arst_n(arst_n),
      .txStrobe(txStrobe), .rxBit(rxBit));

   always #2.5 clock = ~clock;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("compares %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Valid stays up between bits so no edge sees it drop and rise
   task automatic pushBit(input logic b);
      @(negedge clock);
      srcValid = 1'b1;
      srcBit = b;
      expq.push_back(b);
      while (srcReady !== 1'b1) @(negedge clock);
      @(posedge clock);
   endtask

   // Mode moves just after a strobe, far from the tick that samples it
   task automatic setMode(input logic [1:0] m);
      @(posedge txStrobe);
      repeat (2) @(negedge clock);
      kaMode = m;
   endtask

   // Outputs are read at the falling edge, where they have settled
   always @(negedge clock) begin
      if (arst_n !== 1'b1) begin
         n = 0;
         zRun = 0;
         ones = 0;
         expq.delete();
      end else if (txStrobe === 1'b1) begin
         if (kaActive === 1'b1) begin
            kaCount++;
            if (kaMode == tpk_pkg::KA_LOOP)
               chk(txBit, rxBit);
            else if (kaMode == tpk_pkg::KA_FRAMED && n % 193 == 0)
               chk(txBit, FP[n / 193 % 12]);
            else
               chk(txBit, 1'b1);
         end else if (expq.size() == 0)
            chk(kaActive, 1'b1);
         else
            chk(txBit, expq.pop_front());
         zRun = (txBit === 1'b1) ? 0 : zRun + 1;
         ones += (txBit === 1'b1);
         chk(zRun <= 80, 1'b1);
         n++;
      end
   end

   initial begin
      #(96000 * 5);
      errTotal++;
      results();
   end

   initial begin
      clock = 0;
      arst_n = 0;
      srcBit = 0;
      srcValid = 0;
      kaMode = tpk_pkg::KA_FRAMED;
      errTotal = 0;
      cmpCount = 0;
      kaCount = 0;
      repeat (6) @(negedge clock);
      chk({txBit, txStrobe, kaActive, srcReady}, 8'h0a);
      arst_n = 1;
      foreach (rows[r]) begin
         for (int i = 7; i >= 0; i--) pushBit(rows[r][i]);
         $display("row %0d done", r);
      end
      @(negedge clock);
      srcValid = 0;
      kaMode = tpk_pkg::KA_LOOP;
      k0 = kaCount;
      // Long zero payload must be cut off by loopback keep-alive
      repeat (60) pushBit(1'b0);
      repeat (8) pushBit(1'b1);
      @(negedge clock);
      srcValid = 0;
      for (int w = 0; w < 40000 && expq.size() > 0; w++) @(negedge clock);
      chk(expq.size() == 0, 1'b1);
      chk(kaCount - k0 >= 193, 1'b1);
      chk(ones * 8 >= n, 1'b1);
      $display("zero run test done");
      arst_n = 0;
      kaMode = tpk_pkg::KA_ONES;
      repeat (6) @(negedge clock);
      chk({txBit, txStrobe, kaActive, srcReady}, 8'h0a);
      k0 = kaCount;
      arst_n = 1;
      repeat (100 * 129) @(negedge clock);
      setMode(tpk_pkg::KA_DEFAULT);
      repeat (85 * 129) @(negedge clock);
      setMode(tpk_pkg::KA_FRAMED);
      repeat (15 * 129) @(negedge clock);
      chk(kaCount - k0 >= 193, 1'b1);
      $display("second reset test done");
      results();
   end
endmodule
`default_nettype wire

// file: tpk_line_model.sv
// Line-side model: plays the network's regenerated receive stream.
// Assumes txStrobe marks each new line bit from the guard.
`timescale 1ns/1ps
`default_nettype none
module tpk_line_model (
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic txStrobe,
   output wire logic rxBit
);
   logic [6:0] lfsrReg;
   // Bits move once per line bit, so a stuck loopback shows at once
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lfsrReg <= 7'h5a;
      end else if (txStrobe) begin
         lfsrReg <= {lfsrReg[5:0], lfsrReg[6] ^ lfsrReg[5]};
      end
   end
   assign rxBit = lfsrReg[6];
endmodule
`default_nettype wire

// file: tpk_pkg.sv
// Constants for the 1.544 Mbps pulse density keep-alive block.
// Assumes one 200 MHz system clock; the line bit rate is an enable.
package tpk_pkg;
   localparam longint CLK_HZ      = 64'd200_000_000;
   localparam longint LINE_BPS    = 64'd1_544_000;
   // Bit period rounds down so the line never runs slow
   localparam int     BIT_DIV     = int'(CLK_HZ / LINE_BPS);
   localparam int     ZERO_MAX    = 80;
   localparam int     ONE_CREDIT  = 7;
   localparam int     CREDIT_CAP  = 56;
   localparam int     FRAME_BITS  = 193;
   localparam int     FRAME_COUNT = 12;
   localparam int     KA_MIN_BITS = 193;
   localparam logic [11:0] FRAME_PATTERN_RST = 12'h8d6;

   typedef enum logic [1:0] {
      KA_DEFAULT = 2'b00,
      KA_ONES    = 2'b01,
      KA_FRAMED  = 2'b10,
      KA_LOOP    = 2'b11
   } tpk_ka_t;

   typedef enum logic {
      ST_DATA = 1'b0,
      ST_KEEP = 1'b1
   } tpk_state_t;
endpackage
